// ---- src/swc_pkg.sv ----
/*
 * constants shared by the stream width converter and its fifo.
 * assumes a single clock domain and fixed widths; non-integer ratio built
 * as upsize to the common width, then downsize.
 */
`default_nettype none
package swc_pkg;
  // ********************
  // widths
  // ********************
  localparam int unsigned SWC_IN_BYTES   = 4;
  localparam int unsigned SWC_OUT_BYTES  = 6;
  localparam int unsigned SWC_LCM_BYTES  = 12;
  localparam int unsigned SWC_UP_RATIO   = SWC_LCM_BYTES / SWC_IN_BYTES;
  localparam int unsigned SWC_DN_RATIO   = SWC_LCM_BYTES / SWC_OUT_BYTES;
  localparam int unsigned SWC_BYTE_W     = 8;
  localparam int unsigned SWC_USER_PER_B = 1;
  localparam int unsigned SWC_ID_W       = 4;
  localparam int unsigned SWC_DEST_W     = 4;
  localparam int unsigned SWC_IN_DW      = SWC_IN_BYTES * SWC_BYTE_W;
  localparam int unsigned SWC_OUT_DW     = SWC_OUT_BYTES * SWC_BYTE_W;
  localparam int unsigned SWC_WIDE_DW    = SWC_LCM_BYTES * SWC_BYTE_W;
  localparam int unsigned SWC_IN_UW      = SWC_IN_BYTES * SWC_USER_PER_B;
  localparam int unsigned SWC_OUT_UW     = SWC_OUT_BYTES * SWC_USER_PER_B;
  localparam int unsigned SWC_WIDE_UW    = SWC_LCM_BYTES * SWC_USER_PER_B;
  // ********************
  // fifo and counters
  // ********************
  localparam int unsigned SWC_FIFO_DEPTH = 16;
  localparam int unsigned SWC_UP_CNT_W   = $clog2(SWC_UP_RATIO);
  localparam int unsigned SWC_DN_CNT_W   = $clog2(SWC_DN_RATIO);
  localparam logic [SWC_UP_CNT_W-1:0] SWC_UP_LAST = SWC_UP_CNT_W'(SWC_UP_RATIO - 1);
  localparam logic [SWC_DN_CNT_W-1:0] SWC_DN_LAST = SWC_DN_CNT_W'(SWC_DN_RATIO - 1);
  // payload order: data, keep, strb, user, last, id, dest
  localparam int unsigned SWC_PAY_W = SWC_WIDE_DW + 2 * SWC_LCM_BYTES + SWC_WIDE_UW + 1 + SWC_ID_W + SWC_DEST_W;
endpackage
`default_nettype wire

// ---- src/swc_width_converter.sv ----
/*
 * stream width converter: upsizer, 16-word fifo, downsizer, one clock.
 * assumes upstream and downstream keep valid/payload stable until taken.
 */
// Notes on behaviour
// - upsize packs N narrow beats per wide beat
// - downsize splits wide beat into N narrow beats
// - odd ratio goes up to common width, down
// - user bits follow their bytes, never interpreted
// - user bits per byte same both sides
// - only same id/dest, no inner last, merge
// - last or id/dest change flushes partial beat
// - unfilled lanes are null, keep/strb low
// - upsize input 1-256, output 2-512 bytes
// - upsize latency at least two plus N
// - downsize input 2-512, output 256-1 bytes
// - downsize first narrow beat after two cycles
// - downsize ready low ratio minus one cycles
// - keep/strb one bit per data byte
`default_nettype none
// ********************
// fifo
// ********************
module swc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem      [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset: contents are only read once written
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // swc_fifo

// ********************
// converter top
// ********************
module swc_width_converter (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           s_tvalid,
  output logic                                s_tready,
  input  wire logic [swc_pkg::SWC_IN_DW-1:0]  s_tdata,
  input  wire logic [swc_pkg::SWC_IN_BYTES-1:0] s_tkeep,
  input  wire logic [swc_pkg::SWC_IN_BYTES-1:0] s_tstrb,
  input  wire logic [swc_pkg::SWC_IN_UW-1:0]  s_tuser,
  input  wire logic                           s_tlast,
  input  wire logic [swc_pkg::SWC_ID_W-1:0]   s_tid,
  input  wire logic [swc_pkg::SWC_DEST_W-1:0] s_tdest,
  output logic                                m_tvalid,
  input  wire logic                           m_tready,
  output logic      [swc_pkg::SWC_OUT_DW-1:0] m_tdata,
  output logic      [swc_pkg::SWC_OUT_BYTES-1:0] m_tkeep,
  output logic      [swc_pkg::SWC_OUT_BYTES-1:0] m_tstrb,
  output logic      [swc_pkg::SWC_OUT_UW-1:0] m_tuser,
  output logic                                m_tlast,
  output logic      [swc_pkg::SWC_ID_W-1:0]   m_tid,
  output logic      [swc_pkg::SWC_DEST_W-1:0] m_tdest
);
  import swc_pkg::*;

  // ********************
  // upsizer state
  // ********************
  logic [SWC_WIDE_DW-1:0]   up_data;
  logic [SWC_LCM_BYTES-1:0] up_keep;
  logic [SWC_LCM_BYTES-1:0] up_strb;
  logic [SWC_WIDE_UW-1:0]   up_user;
  logic                     up_last;
  logic [SWC_ID_W-1:0]      up_id;
  logic [SWC_DEST_W-1:0]    up_dest;
  logic [SWC_UP_CNT_W-1:0]  up_cnt;
  logic                     up_pend;
  logic                     up_filled;
  logic [SWC_WIDE_DW-1:0]   next_up_data;
  logic [SWC_LCM_BYTES-1:0] next_up_keep;
  logic [SWC_LCM_BYTES-1:0] next_up_strb;
  logic [SWC_WIDE_UW-1:0]   next_up_user;
  logic                     next_up_last;
  logic [SWC_ID_W-1:0]      next_up_id;
  logic [SWC_DEST_W-1:0]    next_up_dest;
  logic [SWC_UP_CNT_W-1:0]  next_up_cnt;
  logic                     next_up_pend;
  logic                     next_up_filled;
  logic                     mismatch;
  logic                     take;
  logic                     push;
  logic                     f_in_ready;
  logic                     f_out_valid;
  logic                     f_out_ready;
  logic [SWC_PAY_W-1:0]     f_out_data;

  // a beat with other id/dest must not join the held partial beat
  assign mismatch = s_tvalid && up_filled && !up_pend && (s_tid != up_id || s_tdest != up_dest);
  // input stalls while a wide beat waits for the fifo; costs one bubble per wide beat
  assign s_tready = !up_pend && !mismatch;
  assign take     = s_tvalid && s_tready;
  assign push     = up_pend && f_in_ready;

  always_comb begin
    next_up_data   = up_data;
    next_up_keep   = up_keep;
    next_up_strb   = up_strb;
    next_up_user   = up_user;
    next_up_last   = up_last;
    next_up_id     = up_id;
    next_up_dest   = up_dest;
    next_up_cnt    = up_cnt;
    next_up_pend   = up_pend;
    next_up_filled = up_filled;
    if (push) begin
      // cleared lanes stay null when the next beat flushes early
      next_up_data   = '0;
      next_up_keep   = '0;
      next_up_strb   = '0;
      next_up_user   = '0;
      next_up_last   = 1'b0;
      next_up_cnt    = '0;
      next_up_pend   = 1'b0;
      next_up_filled = 1'b0;
    end else if (mismatch) begin
      next_up_pend = 1'b1;
    end else if (take) begin
      // earliest beat lands in the lowest lanes
      next_up_data[up_cnt * SWC_IN_DW +: SWC_IN_DW]       = s_tdata;
      next_up_keep[up_cnt * SWC_IN_BYTES +: SWC_IN_BYTES] = s_tkeep;
      next_up_strb[up_cnt * SWC_IN_BYTES +: SWC_IN_BYTES] = s_tstrb;
      next_up_user[up_cnt * SWC_IN_UW +: SWC_IN_UW]       = s_tuser;
      next_up_last   = s_tlast;
      next_up_id     = s_tid;
      next_up_dest   = s_tdest;
      next_up_filled = 1'b1;
      if (s_tlast || up_cnt == SWC_UP_LAST) begin
        next_up_pend = 1'b1;
      end else begin
        next_up_cnt = SWC_UP_CNT_W'(up_cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      up_data   <= '0;
      up_keep   <= '0;
      up_strb   <= '0;
      up_user   <= '0;
      up_last   <= 1'b0;
      up_id     <= '0;
      up_dest   <= '0;
      up_cnt    <= '0;
      up_pend   <= 1'b0;
      up_filled <= 1'b0;
    end else begin
      up_data   <= next_up_data;
      up_keep   <= next_up_keep;
      up_strb   <= next_up_strb;
      up_user   <= next_up_user;
      up_last   <= next_up_last;
      up_id     <= next_up_id;
      up_dest   <= next_up_dest;
      up_cnt    <= next_up_cnt;
      up_pend   <= next_up_pend;
      up_filled <= next_up_filled;
    end
  end

  // ********************
  // common-width buffer
  // ********************
  swc_fifo #(
    .WIDTH (SWC_PAY_W),
    .DEPTH (SWC_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (up_pend),
    .in_ready  (f_in_ready),
    .in_data   ({up_data, up_keep, up_strb, up_user, up_last, up_id, up_dest}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ********************
  // downsizer state
  // ********************
  logic [SWC_WIDE_DW-1:0]   dn_data;
  logic [SWC_LCM_BYTES-1:0] dn_keep;
  logic [SWC_LCM_BYTES-1:0] dn_strb;
  logic [SWC_WIDE_UW-1:0]   dn_user;
  logic                     dn_last;
  logic                     dn_lastp;
  logic [SWC_ID_W-1:0]      dn_id;
  logic [SWC_DEST_W-1:0]    dn_dest;
  logic [SWC_DN_CNT_W-1:0]  dn_idx;
  logic                     dn_held;
  logic [SWC_WIDE_DW-1:0]   next_dn_data;
  logic [SWC_LCM_BYTES-1:0] next_dn_keep;
  logic [SWC_LCM_BYTES-1:0] next_dn_strb;
  logic [SWC_WIDE_UW-1:0]   next_dn_user;
  logic                     next_dn_last;
  logic                     next_dn_lastp;
  logic [SWC_ID_W-1:0]      next_dn_id;
  logic [SWC_DEST_W-1:0]    next_dn_dest;
  logic [SWC_DN_CNT_W-1:0]  next_dn_idx;
  logic                     next_dn_held;
  logic                     emit;
  logic                     final_piece;
  logic                     load;

  assign emit        = dn_held && m_tready;
  assign final_piece = (dn_idx == SWC_DN_LAST);
  // reload in the cycle the final piece leaves, so the gap is ratio minus one
  assign f_out_ready = !dn_held || (emit && final_piece);
  assign load        = f_out_valid && f_out_ready;

  always_comb begin
    next_dn_data  = dn_data;
    next_dn_keep  = dn_keep;
    next_dn_strb  = dn_strb;
    next_dn_user  = dn_user;
    next_dn_last  = dn_last;
    next_dn_lastp = dn_lastp;
    next_dn_id    = dn_id;
    next_dn_dest  = dn_dest;
    next_dn_idx   = dn_idx;
    next_dn_held  = dn_held;
    if (load) begin
      {next_dn_data, next_dn_keep, next_dn_strb, next_dn_user,
       next_dn_last, next_dn_id, next_dn_dest} = f_out_data;
      next_dn_idx   = '0;
      next_dn_held  = 1'b1;
      next_dn_lastp = next_dn_last && (SWC_DN_LAST == '0);
    end else if (emit) begin
      if (final_piece) begin
        next_dn_held = 1'b0;
      end else begin
        // shift keeps the outputs straight from flops, lowest lanes first
        next_dn_data  = SWC_WIDE_DW'(dn_data >> SWC_OUT_DW);
        next_dn_keep  = SWC_LCM_BYTES'(dn_keep >> SWC_OUT_BYTES);
        next_dn_strb  = SWC_LCM_BYTES'(dn_strb >> SWC_OUT_BYTES);
        next_dn_user  = SWC_WIDE_UW'(dn_user >> SWC_OUT_UW);
        next_dn_idx   = SWC_DN_CNT_W'(dn_idx + 1'b1);
        next_dn_lastp = dn_last && (next_dn_idx == SWC_DN_LAST);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dn_data  <= '0;
      dn_keep  <= '0;
      dn_strb  <= '0;
      dn_user  <= '0;
      dn_last  <= 1'b0;
      dn_lastp <= 1'b0;
      dn_id    <= '0;
      dn_dest  <= '0;
      dn_idx   <= '0;
      dn_held  <= 1'b0;
    end else begin
      dn_data  <= next_dn_data;
      dn_keep  <= next_dn_keep;
      dn_strb  <= next_dn_strb;
      dn_user  <= next_dn_user;
      dn_last  <= next_dn_last;
      dn_lastp <= next_dn_lastp;
      dn_id    <= next_dn_id;
      dn_dest  <= next_dn_dest;
      dn_idx   <= next_dn_idx;
      dn_held  <= next_dn_held;
    end
  end

  // ********************
  // outputs
  // ********************
  assign m_tvalid = dn_held;
  assign m_tdata  = dn_data[SWC_OUT_DW-1:0];
  assign m_tkeep  = dn_keep[SWC_OUT_BYTES-1:0];
  assign m_tstrb  = dn_strb[SWC_OUT_BYTES-1:0];
  assign m_tuser  = dn_user[SWC_OUT_UW-1:0];
  // last only on the final narrow piece of a wide beat
  assign m_tlast  = dn_lastp;
  assign m_tid    = dn_id;
  assign m_tdest  = dn_dest;
endmodule // swc_width_converter
`default_nettype wire

// ---- bench/swc_checker.sv ----
/*
 * port checker for the stream width converter, attached by bind.
 * assumes one clock, synchronous active-low reset, 4-byte in, 6-byte out.
 */
`default_nettype none
module swc_checker (
  input wire logic                              core_clk,
  input wire logic                              nrst,
  input wire logic                              s_tvalid,
  input wire logic                              s_tready,
  input wire logic                              s_tlast,
  input wire logic [swc_pkg::SWC_ID_W-1:0]      s_tid,
  input wire logic [swc_pkg::SWC_DEST_W-1:0]    s_tdest,
  input wire logic                              m_tvalid,
  input wire logic                              m_tready,
  input wire logic [swc_pkg::SWC_OUT_DW-1:0]    m_tdata,
  input wire logic [swc_pkg::SWC_OUT_BYTES-1:0] m_tkeep,
  input wire logic [swc_pkg::SWC_OUT_BYTES-1:0] m_tstrb,
  input wire logic [swc_pkg::SWC_OUT_UW-1:0]    m_tuser,
  input wire logic                              m_tlast,
  input wire logic [swc_pkg::SWC_ID_W-1:0]      m_tid,
  input wire logic [swc_pkg::SWC_DEST_W-1:0]    m_tdest
);
  timeunit 1ns;
  timeprecision 1ns;
  import swc_pkg::*;
  // ****
  // helper state
  // ****
  logic [1:0] cnt, next_cnt;
  logic [7:0] pkey, next_pkey, fkey, next_fkey;
  logic       piece, next_piece;
  wire        s_hs = s_tvalid && s_tready;
  wire        m_hs = m_tvalid && m_tready;
  wire        mis  = {s_tid, s_tdest} != pkey;
  always_comb begin
    next_cnt = cnt;
    next_pkey = pkey;
    next_piece = piece ^ m_hs;
    next_fkey = m_hs ? {m_tid, m_tdest} : fkey;
    if (s_hs) begin
      next_cnt = (s_tlast || cnt == 2'd2) ? 2'd0 : cnt + 2'd1;
      next_pkey = {s_tid, s_tdest};
    end else if (s_tvalid && cnt != 2'd0 && mis) begin
      // refused beat flushes the partial, so count restarts
      next_cnt = 2'd0;
    end
  end
  always_ff @(posedge core_clk) begin
    cnt <= nrst ? next_cnt : 2'd0;
    piece <= nrst ? next_piece : 1'b0;
    pkey <= next_pkey;
    fkey <= next_fkey;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_fill;
    s_hs && (s_tlast || cnt == 2'd2);
  endsequence
  sequence s_stall;
    m_tvalid && !m_tready;
  endsequence
  property p_out_hold;
    s_stall |=> m_tvalid && $stable({m_tdata, m_tkeep, m_tstrb, m_tuser, m_tlast, m_tid, m_tdest});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output beat changed before taken");
  property p_bubble;
    s_fill |=> !s_tready;
  endproperty
  a_bubble: assert property (p_bubble) else $error("input taken right after wide beat");
  property p_refuse;
    s_tvalid && cnt != 2'd0 && mis |-> !s_tready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("mixed id merged into wide beat");
  property p_last_piece;
    m_tvalid && m_tlast |-> piece;
  endproperty
  a_last_piece: assert property (p_last_piece) else $error("last on first piece");
  property p_piece_next;
    m_hs && !piece |=> m_tvalid;
  endproperty
  a_piece_next: assert property (p_piece_next) else $error("second piece late");
  property p_pair_key;
    m_tvalid && piece |-> {m_tid, m_tdest} == fkey;
  endproperty
  a_pair_key: assert property (p_pair_key) else $error("pieces differ in id or dest");
  property p_null_side;
    m_tvalid |-> ((m_tstrb | m_tuser) & ~m_tkeep) == '0;
  endproperty
  a_null_side: assert property (p_null_side) else $error("strb or user on null lane");
  for (genvar b = 0; b < SWC_OUT_BYTES; b++) begin : g_lane
    property p_null_lane;
      m_tvalid && !m_tkeep[b] |-> m_tdata[b*8 +: 8] == 8'h00;
    endproperty
    a_null_lane: assert property (p_null_lane) else $error("null lane carries data");
  end
endmodule // swc_checker
`default_nettype wire

// ---- bench/swc_sink_model.sv ----
/*
 * downstream sink model: paces ready, prompt, one in four, or stalled.
 * assumes the bench watches handshakes and picks the pace.
 */
`default_nettype none
module swc_sink_model (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [1:0] pace,
  output var logic       m_tready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] tick = 2'd0;
  // ****
  // ready pacing, no ready in reset
  // ****
  always @(posedge core_clk) begin
    tick <= tick + 2'd1;
    m_tready <= nrst && (pace == 2'd0 || (pace == 2'd1 && tick == 2'd3));
  end
endmodule // swc_sink_model
`default_nettype wire

// ---- bench/swc_width_converter_tb.sv ----
/*
 * bench for the stream width converter: beat table, slow sink,
 * fifo fill and drain, reset in mid-run; reference packer for expectations.
 * assumes 4-byte in, 12-byte common, 6-byte out widths of swc_pkg.
 */
`default_nettype none
module swc_width_converter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import swc_pkg::*;
  typedef struct packed {logic [31:0] d; logic [3:0] k, s; logic l; logic [3:0] i;} swc_row_t;
  logic core_clk = 1'b0, nrst = 1'b0, s_tvalid = 1'b0, s_tlast = 1'b0;
  logic s_tready, m_tvalid, m_tready, m_tlast, full;
  logic [SWC_IN_DW-1:0] s_tdata = '0;
  logic [3:0] s_tkeep = '0, s_tstrb = '0, s_tuser = '0, s_tid = '0, s_tdest = '0, m_tid, m_tdest, wid;
  logic [SWC_OUT_DW-1:0] m_tdata;
  logic [5:0] m_tkeep, m_tstrb, m_tuser;
  logic [1:0] pace = 2'd0;
  logic [95:0] wd = '0;
  logic [11:0] wk = '0, ws = '0;
  logic [74:0] exp_q[$];
  int errors = 0, n_checks = 0, cyc = 0, wc = 0, lim = 1000, n;
  swc_row_t rows [10] = '{
    '{32'h03020100, 4'hf, 4'hf, 1'b0, 4'h1}, '{32'h07060504, 4'hf, 4'h5, 1'b0, 4'h1},
    '{32'h0b0a0908, 4'hf, 4'hf, 1'b1, 4'h1}, '{32'h0f0e0d0c, 4'hf, 4'hf, 1'b1, 4'h2},
    '{32'h13121110, 4'hf, 4'ha, 1'b0, 4'h2}, '{32'h17161514, 4'hf, 4'hf, 1'b1, 4'h2},
    '{32'h00001918, 4'h3, 4'h1, 1'b0, 4'h3}, '{32'h1f1e1d1c, 4'hf, 4'hf, 1'b0, 4'h4},
    '{32'h23222120, 4'hf, 4'hf, 1'b0, 4'h4}, '{32'h27262524, 4'hf, 4'hf, 1'b0, 4'h4}};
  swc_width_converter u_dut (.core_clk, .nrst, .s_tvalid, .s_tready, .s_tdata, .s_tkeep, .s_tstrb, .s_tuser,
    .s_tlast, .s_tid, .s_tdest, .m_tvalid, .m_tready, .m_tdata, .m_tkeep, .m_tstrb, .m_tuser, .m_tlast,
    .m_tid, .m_tdest);
  swc_sink_model u_sink (.core_clk, .nrst, .pace, .m_tready);
  always #25 core_clk = ~core_clk;
  // ****
  // checking and reference packer
  // ****
  task automatic chk(input string nm, input logic [74:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic flush(input logic l);
    exp_q.push_back({wd[47:0], wk[5:0], ws[5:0], ws[5:0], 1'b0, wid, ~wid});
    exp_q.push_back({wd[95:48], wk[11:6], ws[11:6], ws[11:6], l, wid, ~wid});
    {wd, wk, ws, wc} = '0;
  endtask
  // full stays low unless the beat waits lim cycles; then the sink is freed
  task automatic put(input logic [31:0] d, input logic [3:0] k, s, input logic l, input logic [3:0] i);
    {s_tvalid, s_tdata, s_tkeep, s_tstrb, s_tuser, s_tlast, s_tid, s_tdest} <= {1'b1, d, k, s, s, l, i, ~i};
    for (int w = 0; s_tready !== 1'b1 || w == 0; w++) begin
      if (w == lim) begin
        full = 1'b1;
        pace <= 2'd0;
      end
      @(negedge core_clk);
    end
    if (wc != 0 && i != wid) flush(1'b0);
    wd[wc*32 +: 32] = d;
    wk[wc*4 +: 4] = k;
    ws[wc*4 +: 4] = s;
    wid = i;
    wc++;
    if (l || wc == 3) flush(l);
    @(posedge core_clk);
  endtask
  task automatic idle;
    s_tvalid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic drain;
    for (int w = 0; w < 400 && exp_q.size() != 0; w++) @(posedge core_clk);
    @(negedge core_clk);
    chk("drained", {exp_q.size() == 0, m_tvalid}, 75'd2);
    @(posedge core_clk);
  endtask
  always @(negedge core_clk) begin
    if (nrst && m_tvalid === 1'b1 && m_tready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra beat", 75'd1, 75'd0);
      else chk("out beat", {m_tdata, m_tkeep, m_tstrb, m_tuser, m_tlast, m_tid, m_tdest}, exp_q.pop_front());
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      close_out();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset state", {s_tready, m_tvalid}, 75'd2);
    @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int p = 0; p < 2; p++) begin
      foreach (rows[r]) put(rows[r].d, rows[r].k, rows[r].s, rows[r].l, rows[r].i);
      idle();
      drain();
      if (p == 0) begin
        // slow sink under back-to-back beats
        pace <= 2'd1;
        for (n = 0; n < 9; n++) put(32'h40404040 + n, 4'hf, 4'hf, n == 4, 4'h5);
        idle();
        drain();
        // stalled sink: fill the fifo until it refuses, then drain
        {full, lim} = {1'b0, 32'd40};
        pace <= 2'd2;
        for (n = 0; n < 24 && !full; n++) put(32'h50505050 + n, 4'hf, 4'hf, 1'b1, 4'h6);
        chk("fill refusal", {full, n > SWC_FIFO_DEPTH}, 75'd3);
        lim = 1000;
        idle();
        drain();
        // reset with a wide beat queued and a partial held
        pace <= 2'd2;
        put(32'h60606060, 4'hf, 4'hf, 1'b1, 4'h7);
        put(32'h61616161, 4'hf, 4'hf, 1'b0, 4'h7);
        idle();
        nrst <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk("mid reset", {s_tready, m_tvalid}, 75'd2);
        @(posedge core_clk);
        nrst <= 1'b1;
        pace <= 2'd0;
        exp_q.delete();
        {wd, wk, ws, wc} = '0;
        // first beat only after the release edge has passed
        @(posedge core_clk);
      end
    end
    close_out();
  end
endmodule // swc_width_converter_tb
bind swc_width_converter swc_checker u_chk (.core_clk, .nrst, .s_tvalid, .s_tready, .s_tlast, .s_tid, .s_tdest,
  .m_tvalid, .m_tready, .m_tdata, .m_tkeep, .m_tstrb, .m_tuser, .m_tlast, .m_tid, .m_tdest);
`default_nettype wire
